// *** common/pot_pkg.sv ***
/*
  Shared constants for the wiper pot serial link: register map,
  reset values, identification byte layout and timing counts.
  Assumes both link ends and the bench import nothing and refer
  to every name as pot_pkg::name.
*/
package pot_pkg;
  // Register addresses as seen in the address byte
  localparam logic [7:0] WIPER_ADDR = 8'h00;
  localparam logic [7:0] ACR_ADDR = 8'h10;
  // Reset values
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] ACR_RESET = 8'h40;
  localparam int RUN_BIT = 6;
  // Device prefix in the identification byte; value is arbitrary
  localparam logic [4:0] DEV_PREFIX = 5'h0B;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // Bit counter positions within a nine-clock byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Reference clock and settle delay after leaving shutdown
  localparam int REF_PERIOD_NS = 50;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC =
    (SETTLE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  // Master quarter-bit length in reference clocks
  localparam int QTR_CYC_DEF = 5;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
endpackage

// *** common/pot_link_if.sv ***
/*
  Two-wire link between the bus master and the pot device.
  Assumes open-drain wires with pull-ups: a driver only pulls low,
  and a released wire reads high. Nothing else drives the wires.
*/
`timescale 1ns/10ps
interface pot_link_if;
  // Master drivers
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  // Device drivers
  logic d_sda_o;
  logic d_sda_oe;
  // Resolved wire levels
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport master (
    output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
    input sda
  );
  modport device (
    output d_sda_o, d_sda_oe,
    input scl, sda
  );
endinterface

// *** src/pot_bus_master.sv ***
/*
  Bus master end: takes one register write or one-byte read per
  command and plays it out on the link, generating the serial clock
  from ref_clk by a divider.
  Assumes the device never stretches the clock and that the command
  fields stay stable while cmd_valid is high.
*/
`timescale 1ns/10ps
module pot_bus_master #(
  parameter int QTR_CYC = pot_pkg::QTR_CYC_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  pot_link_if.master link,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [1:0] cmd_sel,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  // Response
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [7:0] rsp_rdata
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} mst_t;

  mst_t st_q;
  logic [7:0] qcnt_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic [2:0] sda_s_q;
  logic sda_f_q;
  logic sda_smp_q;
  logic rd_q;
  logic [1:0] sel_q;
  logic [7:0] reg_q;
  logic [7:0] wdata_q;
  logic scl_lvl;
  logic sda_lvl;
  logic tick;
  logic sym_end;
  logic rx;

  assign tick = qcnt_q == 8'(QTR_CYC - 1);
  assign sym_end = tick && qtr_q == pot_pkg::Q_LAST;
  assign rx = byte_q == 2'h3;
  assign cmd_ready = st_q == M_IDLE;

  // Quarter-bit divider, idle while no transfer runs
  always_ff @(posedge ref_clk) begin
    if (rst || st_q == M_IDLE) begin
      qcnt_q <= 8'h00;
      qtr_q <= 2'h0;
    end else if (tick) begin
      qcnt_q <= 8'h00;
      qtr_q <= qtr_q + 2'h1;
    end else begin
      qcnt_q <= qcnt_q + 8'h01;
    end
  end

  // Wire levels per symbol; byte data moves only while the clock is low
  always_comb begin
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    unique case (st_q)
      M_IDLE: begin
      end
      M_START: begin
        scl_lvl = qtr_q == 2'h1 || qtr_q == 2'h2;
        sda_lvl = qtr_q < 2'h2;
      end
      M_BYTE: begin
        scl_lvl = qtr_q == 2'h1 || qtr_q == 2'h2; // see R10
        if (bit_q == pot_pkg::BIT_ACK) begin
          sda_lvl = 1'b1; // see R14 see R20
        end else begin
          sda_lvl = rx ? 1'b1 : sh_q[7]; // see R9
        end
      end
      M_STOP: begin
        scl_lvl = qtr_q != 2'h0;
        sda_lvl = qtr_q >= 2'h2;
      end
    endcase
  end

  // Open-drain drivers: only ever pull low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.m_scl_oe <= 1'b0;
      link.m_sda_oe <= 1'b0;
    end else begin
      link.m_scl_oe <= ~scl_lvl;
      link.m_sda_oe <= ~sda_lvl;
    end
  end
  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;

  // Data wire through three flops; accept once last two agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_s_q <= 3'h7;
      sda_f_q <= 1'b1;
      sda_smp_q <= 1'b1;
    end else begin
      sda_s_q <= {sda_s_q[1:0], link.sda};
      if (sda_s_q[2] == sda_s_q[1]) begin
        sda_f_q <= sda_s_q[2];
      end
      if (tick && qtr_q == pot_pkg::Q_SAMPLE) begin
        sda_smp_q <= sda_f_q; // see R21
      end
    end
  end

  // Transfer sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= M_IDLE;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      sel_q <= 2'h0;
      reg_q <= 8'h00;
      wdata_q <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        M_IDLE: begin
          if (cmd_valid) begin
            st_q <= M_START;
            byte_q <= 2'h0;
            rd_q <= cmd_read;
            sel_q <= cmd_sel;
            reg_q <= cmd_reg;
            wdata_q <= cmd_wdata;
            rsp_nack <= 1'b0;
          end
        end
        M_START: begin
          if (sym_end) begin
            st_q <= M_BYTE;
            bit_q <= 4'h0;
            // First ID is always write direction // see R17 see R19
            sh_q <= {pot_pkg::DEV_PREFIX, sel_q,
              byte_q == 2'h0 ? pot_pkg::DIR_WRITE : pot_pkg::DIR_READ};
          end
        end
        M_BYTE: begin
          if (sym_end && bit_q != pot_pkg::BIT_ACK) begin
            sh_q <= {sh_q[6:0], sda_smp_q};
            bit_q <= bit_q + 4'h1;
          end else if (sym_end) begin
            bit_q <= 4'h0;
            if (!rx && sda_smp_q) begin
              rsp_nack <= 1'b1;
              st_q <= M_STOP;
            end else begin
              unique case (byte_q)
                2'h0: begin
                  byte_q <= 2'h1;
                  sh_q <= reg_q;
                end
                2'h1: begin
                  byte_q <= 2'h2;
                  sh_q <= wdata_q;
                  if (rd_q) begin
                    st_q <= M_START; // see R19
                  end
                end
                2'h2: begin
                  byte_q <= 2'h3;
                  if (!rd_q) begin
                    st_q <= M_STOP; // see R18
                  end
                end
                2'h3: begin
                  rsp_rdata <= sh_q;
                  st_q <= M_STOP; // see R20
                end
              endcase
            end
          end
        end
        M_STOP: begin
          if (sym_end) begin
            st_q <= M_IDLE;
            rsp_valid <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// *** src/pot_wiper_dev.sv ***
/*
  Device end of the wiper pot: serial slave on the link clock, with
  the wiper and access control registers on ref_clk.
  Assumes the master keeps data still while the clock is high, leaves
  a free-bus gap of several ref_clk periods between frames, and that
  rst is held through power-up.
*/
// Function
// R1: Eight-bit wiper register, 00h low, FFh high
// R2: Wiper register resets to 80h
// R3: Address 0 wiper, address 10h access control
// R4: Only bit 6 exists; others read zero
// R5: Run bit 0 opens array, wiper low
// R6: Run bit resets to 1
// R7: Shutdown keeps wiper; settle before tap returns
// R8: Brown-out during shutdown presets wiper mid-scale
// R9: Bytes move most significant bit first
// R10: Master changes data only while clock low
// R11: Data driver released after power-up
// R12: Wait for START; ignore START during reset
// R13: STOP returns interface to idle
// R14: Receiver pulls data low on ninth clock
// R15: Acknowledge matching ID, address, write data
// R16: Master acknowledges all read bytes but last
// R17: ID is prefix, select pins, direction bit
// R18: Write commits at ninth clock of data
// R19: Read uses write ID, address, restart, read ID
// R20: Master ends read with NACK then STOP
// R21: Sample on rising, drive after falling edge
// R22: Extra reads repeat register; unmapped writes dropped
`timescale 1ns/10ps
module pot_wiper_dev #(
  parameter int SETTLE_CYC = pot_pkg::SETTLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  pot_link_if.device link,
  // Address select straps
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  // Supply monitor
  input wire logic brown_out,
  // Analog control
  output logic [7:0] wiper_tap,
  output logic run_not_shutdown_bit,
  output logic array_open,
  output logic wiper_settled
);
  typedef enum logic [2:0] {
    L_IDLE, L_ID, L_ADDR, L_WDATA, L_RDATA, L_SKIP
  } lnk_t;

  // Link clock domain
  lnk_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] addr_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic ack_q;
  logic rd_q;
  logic wr_tgl_q;
  logic start_tgl_q;
  logic stop_tgl_q;
  logic start_seen_q;
  logic stop_seen_q;
  logic sda_oe_q;
  logic [2:0] sel_hi_s_q;
  logic [2:0] sel_lo_s_q;
  logic [1:0] sel_q;
  logic [7:0] byte_in;
  logic id_hit;
  logic [7:0] rd_word;
  // Reference clock domain
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] seen_q;
  logic [3:0] agree;
  logic [2:0] ev;
  logic busy_q;
  logic [7:0] wiper_q;
  logic run_q;
  logic [7:0] acr_word;
  logic [15:0] snap_q;
  logic [15:0] settle_q;

  // START and STOP seen as data edges while the clock is high
  always_ff @(negedge link.sda or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'b0; // see R12
    end else if (link.scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge link.sda or posedge rst) begin
    if (rst) begin
      stop_tgl_q <= 1'b0;
    end else if (link.scl) begin
      stop_tgl_q <= ~stop_tgl_q; // see R13
    end
  end

  // Select straps through three flops; accept once last two agree
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      sel_hi_s_q <= 3'h0;
      sel_lo_s_q <= 3'h0;
      sel_q <= 2'h0;
    end else begin
      sel_hi_s_q <= {sel_hi_s_q[1:0], addr_select_hi};
      sel_lo_s_q <= {sel_lo_s_q[1:0], addr_select_lo};
      if (sel_hi_s_q[2] == sel_hi_s_q[1]) begin
        sel_q[1] <= sel_hi_s_q[2];
      end
      if (sel_lo_s_q[2] == sel_lo_s_q[1]) begin
        sel_q[0] <= sel_lo_s_q[2];
      end
    end
  end

  // Byte being completed and its match against our identity
  assign byte_in = {sh_q[6:0], link.sda}; // see R9
  assign id_hit = byte_in[7:3] == pot_pkg::DEV_PREFIX
    && byte_in[2:1] == sel_q; // see R17

  // Read data from the frozen snapshot; unmapped reads give zero
  always_comb begin
    rd_word = 8'h00;
    if (addr_q == pot_pkg::WIPER_ADDR) begin
      rd_word = snap_q[7:0];
    end else if (addr_q == pot_pkg::ACR_ADDR) begin
      rd_word = snap_q[15:8];
    end
  end

  // Frame state machine; every input bit taken on the rising edge
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      st_q <= L_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else if (start_tgl_q != start_seen_q) begin
      // First clock after a START is bit 7 of the ID byte
      start_seen_q <= start_tgl_q; // see R12
      stop_seen_q <= stop_tgl_q;
      st_q <= L_ID;
      bit_q <= 4'h1;
      sh_q <= {7'h00, link.sda}; // see R21
      ack_q <= 1'b0;
    end else if (stop_tgl_q != stop_seen_q) begin
      // Stray clocks after a STOP must not finish a cut byte
      stop_seen_q <= stop_tgl_q; // see R13
      st_q <= L_IDLE;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      unique case (st_q)
        L_IDLE, L_SKIP: begin
          ack_q <= 1'b0;
        end
        L_RDATA: begin
          ack_q <= 1'b0;
          if (bit_q != pot_pkg::BIT_ACK) begin
            tx_q <= {tx_q[6:0], 1'b0}; // see R9
            bit_q <= bit_q + 4'h1;
          end else if (!link.sda) begin
            tx_q <= rd_word; // see R16 see R22
            bit_q <= 4'h0;
          end else begin
            st_q <= L_IDLE; // see R20
            bit_q <= 4'h0;
          end
        end
        L_ID, L_ADDR, L_WDATA: begin
          if (bit_q != pot_pkg::BIT_ACK) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 4'h1;
            if (bit_q == pot_pkg::BIT_LAST) begin
              unique case (st_q)
                L_ID: begin
                  ack_q <= id_hit; // see R15
                  rd_q <= byte_in[0] == pot_pkg::DIR_READ;
                end
                L_ADDR: begin
                  ack_q <= 1'b1; // see R15
                  addr_q <= byte_in;
                end
                L_WDATA: begin
                  ack_q <= 1'b1; // see R15
                  wr_data_q <= byte_in;
                  wr_addr_q <= addr_q;
                end
              endcase
            end
          end else begin
            // Rising edge of the ninth clock
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            unique case (st_q)
              L_ID: begin
                if (!ack_q) begin
                  st_q <= L_SKIP;
                end else if (rd_q) begin
                  st_q <= L_RDATA; // see R19
                  tx_q <= rd_word;
                end else begin
                  st_q <= L_ADDR;
                end
              end
              L_ADDR: begin
                st_q <= L_WDATA;
              end
              L_WDATA: begin
                wr_tgl_q <= ~wr_tgl_q; // see R18
                st_q <= L_SKIP;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Output driver changes only after falling edges; released at reset
  always_ff @(negedge link.scl or posedge rst) begin
    if (rst) begin
      sda_oe_q <= 1'b0; // see R11
    end else begin
      sda_oe_q <= (bit_q == pot_pkg::BIT_ACK && ack_q) // see R14
        || (st_q == L_RDATA && bit_q != pot_pkg::BIT_ACK
        && !tx_q[7]); // see R21
    end
  end
  assign link.d_sda_oe = sda_oe_q;
  assign link.d_sda_o = 1'b0;

  // Toggles and brown-out into ref_clk through three flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      seen_q <= 4'h0;
    end else begin
      s1_q <= {brown_out, wr_tgl_q, stop_tgl_q, start_tgl_q};
      s2_q <= s1_q;
      s3_q <= s2_q;
      seen_q <= (agree & s3_q) | (~agree & seen_q);
    end
  end
  assign agree = ~(s2_q ^ s3_q);
  assign ev = agree[2:0] & (s3_q[2:0] ^ seen_q[2:0]);

  // Frame activity; START wins if both land in one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (ev[0]) begin
      busy_q <= 1'b1;
    end else if (ev[1]) begin
      busy_q <= 1'b0; // see R13
    end
  end

  // Wiper register; brown-out preset beats a same-cycle write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wiper_q <= pot_pkg::WIPER_RESET; // see R2
    end else if (seen_q[3] && !run_q) begin
      wiper_q <= pot_pkg::WIPER_RESET; // see R8
    end else if (ev[2] && wr_addr_q == pot_pkg::WIPER_ADDR) begin
      wiper_q <= wr_data_q; // see R1 see R3
    end
  end

  // Run bit; other addresses are acknowledged but dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= pot_pkg::ACR_RESET[pot_pkg::RUN_BIT]; // see R6
    end else if (ev[2] && wr_addr_q == pot_pkg::ACR_ADDR) begin
      run_q <= wr_data_q[pot_pkg::RUN_BIT]; // see R3 see R22
    end
  end
  assign acr_word = 8'(run_q) << pot_pkg::RUN_BIT; // see R4

  // Snapshot frozen during frames so the link reads a stable word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap_q <= {pot_pkg::ACR_RESET, pot_pkg::WIPER_RESET};
    end else if (!busy_q) begin
      snap_q <= {acr_word, wiper_q};
    end
  end

  // Settle delay after leaving shutdown; wiper value kept throughout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      settle_q <= 16'h0000;
    end else if (!run_q) begin
      settle_q <= 16'(SETTLE_CYC); // see R7
    end else if (settle_q != 16'h0000) begin
      settle_q <= settle_q - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wiper_settled <= 1'b1;
    end else begin
      wiper_settled <= run_q && settle_q == 16'h0000; // see R7
    end
  end

  // Analog side controls
  assign wiper_tap = wiper_q;
  assign run_not_shutdown_bit = run_q;
  assign array_open = ~run_q; // see R5
endmodule

// *** sim/pot_assertions.sv ***
/*
  Wire-level checker for the first pot link, where both ends are
  design modules.
  Assumes the master runs at its default quarter-bit length.
*/
`timescale 1ns/10ps
module pot_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link wires
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // One domain; wires are seen through the reference clock
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_idle_after_rst: assert property (
    $fell(rst) |-> !m_sda_oe && !d_sda_oe && scl)
    else $error("link not released after reset");
  // Device may only move its data just after the clock falls
  a_dev_drive_edge: assert property (
    $changed(d_sda_oe) |-> $fell(scl))
    else $error("device data moved away from clock fall");
  a_dev_hold_bit: assert property (
    $rose(d_sda_oe) |-> d_sda_oe [*8])
    else $error("device ack or bit too short");
  a_start_clock_low: assert property (
    ($fell(sda) && scl) |-> ##[1:12] !scl)
    else $error("start not followed by clock low");
  a_stop_holds: assert property (
    ($rose(sda) && scl) |-> sda [*4])
    else $error("stop not held");
  a_stop_quiet: assert property (
    ($rose(sda) && scl) |-> !d_sda_oe [*8])
    else $error("device drives after stop");
  a_scl_low_time: assert property (
    $fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  // Only start and stop may move data mid-way through a high phase
  a_sda_mid_high: assert property (
    ($changed(m_sda_oe) && scl) |-> $past(scl, 3) ##3 scl)
    else $error("master data moved near a clock edge");

  // Main traffic seen
  c_start: cover property ($fell(sda) && scl);
  c_dev_ack: cover property ($rose(d_sda_oe));
  c_stop: cover property ($rose(sda) && scl);
endmodule

// *** sim/testbench.sv ***
/*
  Testbench: master and device joined on one link, plus a second
  device driven bit by bit by the bench on a second link.
  Assumes the bench drives inputs 1 ns after the clock edge.
*/
`timescale 1ns/10ps
module testbench;
  localparam int SETTLE = 60;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rst2 = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [1:0] cmd_sel = 2'h0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [1:0] straps = 2'h2;
  logic brown_out = 1'b0;
  logic cmd_ready, rsp_valid, rsp_nack, run_bit, array_open, settled;
  logic [7:0] rsp_rdata, wiper_tap, wiper2;
  int n_mismatch = 0;
  int checks = 0;

  pot_link_if link ();
  pot_link_if link2 ();
  pot_bus_master pot_bus_master_inst (.ref_clk(ref_clk), .rst(rst),
    .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_sel(cmd_sel), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
  pot_wiper_dev #(.SETTLE_CYC(SETTLE)) pot_wiper_dev_inst (
    .ref_clk(ref_clk), .rst(rst), .link(link),
    .addr_select_hi(straps[1]), .addr_select_lo(straps[0]),
    .brown_out(brown_out), .wiper_tap(wiper_tap),
    .run_not_shutdown_bit(run_bit), .array_open(array_open),
    .wiper_settled(settled));
  // Second device, its master played by the bench
  pot_wiper_dev pot_wiper_dev_inst2 (.ref_clk(ref_clk), .rst(rst2),
    .link(link2), .addr_select_hi(straps[1]),
    .addr_select_lo(straps[0]), .brown_out(1'b0),
    .wiper_tap(wiper2), .run_not_shutdown_bit(), .array_open(),
    .wiper_settled());
  pot_assertions pot_assertions_inst (.ref_clk(ref_clk), .rst(rst),
    .m_sda_oe(link.m_sda_oe), .d_sda_oe(link.d_sda_oe),
    .scl(link.scl), .sda(link.sda));

  // 20 MHz reference
  always #25 ref_clk = ~ref_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Gap first, so the device sees a free bus before each start
  task automatic cmd(input logic rd, input logic [1:0] sel,
      input logic [7:0] ra, input logic [7:0] wd);
    repeat (8) @(posedge ref_clk);
    #1;
    cmd_read = rd;
    cmd_sel = sel;
    cmd_reg = ra;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    chk({7'h00, cmd_ready}, 8'h00);
    for (int i = 0; i < 2000 && rsp_valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({6'h00, rsp_valid, cmd_ready}, 8'h03);
  endtask

  task automatic brown_pulse();
    brown_out = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    brown_out = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic test_reset();
    chk(wiper_tap, pot_pkg::WIPER_RESET);
    chk({7'h00, run_bit}, 8'h01);
    chk({7'h00, array_open}, 8'h00);
    chk({6'h00, link.m_sda_oe, link.d_sda_oe}, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_wiper();
    logic [7:0] v[3] = '{8'h00, 8'hFF, 8'h96};
    foreach (v[i]) begin
      cmd(1'b0, straps, pot_pkg::WIPER_ADDR, v[i]);
      chk({7'h00, rsp_nack}, 8'h00);
      chk(wiper_tap, v[i]);
      cmd(1'b1, straps, pot_pkg::WIPER_ADDR, 8'h00);
      chk(rsp_rdata, v[i]);
    end
    $display("test wiper done");
  endtask

  task automatic test_acr();
    int n;
    cmd(1'b0, straps, pot_pkg::ACR_ADDR, 8'hFF);
    cmd(1'b1, straps, pot_pkg::ACR_ADDR, 8'h00);
    chk(rsp_rdata, 8'h40);
    cmd(1'b0, straps, pot_pkg::WIPER_ADDR, 8'h33);
    brown_pulse();
    chk(wiper_tap, 8'h33);
    cmd(1'b0, straps, pot_pkg::ACR_ADDR, 8'h00);
    chk({6'h00, run_bit, array_open}, 8'h01);
    chk({7'h00, settled}, 8'h00);
    chk(wiper_tap, 8'h33);
    cmd(1'b1, straps, pot_pkg::ACR_ADDR, 8'h00);
    chk(rsp_rdata, 8'h00);
    brown_pulse();
    chk(wiper_tap, pot_pkg::WIPER_RESET);
    cmd(1'b0, straps, pot_pkg::ACR_ADDR, 8'h40);
    chk({6'h00, run_bit, settled}, 8'h02);
    // Count the remaining settle time from the response
    n = 0;
    while (settled !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({7'h00, n >= SETTLE - 40 && n <= SETTLE - 22}, 8'h01);
    $display("test shutdown done");
  endtask

  task automatic test_unmapped();
    cmd(1'b0, straps, 8'h05, 8'h77);
    chk({7'h00, rsp_nack}, 8'h00);
    chk(wiper_tap, pot_pkg::WIPER_RESET);
    cmd(1'b1, straps, 8'h05, 8'h00);
    chk(rsp_rdata, 8'h00);
    cmd(1'b0, ~straps, pot_pkg::WIPER_ADDR, 8'h5A);
    chk({7'h00, rsp_nack}, 8'h01);
    chk(wiper_tap, pot_pkg::WIPER_RESET);
    // New straps settle over one throw-away frame
    straps = 2'h1;
    cmd(1'b1, straps, pot_pkg::WIPER_ADDR, 8'h00);
    cmd(1'b0, straps, pot_pkg::WIPER_ADDR, 8'hC3);
    chk({7'h00, rsp_nack}, 8'h00);
    chk(wiper_tap, 8'hC3);
    $display("test unmapped done");
  endtask

  // One bench master step on the second link
  task automatic bb(input logic c, input logic d);
    repeat (4) @(posedge ref_clk);
    #1;
    link2.m_scl_oe = ~c;
    link2.m_sda_oe = ~d;
  endtask

  // Data moves only with the clock already low
  task automatic tx(input logic [7:0] v, input int n, output logic ack);
    for (int i = 7; i > 7 - n; i--) begin
      bb(1'b0, v[i]);
      bb(1'b1, v[i]);
      bb(1'b0, v[i]);
    end
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    ack = link2.sda;
    bb(1'b0, 1'b1);
  endtask

  task automatic frame(input logic [7:0] d, input int n,
      output logic [2:0] a);
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    tx({pot_pkg::DEV_PREFIX, straps, pot_pkg::DIR_WRITE}, 8, a[2]);
    tx(pot_pkg::WIPER_ADDR, 8, a[1]);
    tx(d, n, a[0]);
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // Read one byte; ack low asks for more, high ends the read
  task automatic rx(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      v[i] = link2.sda;
      bb(1'b0, 1'b1);
    end
    bb(1'b0, last);
    bb(1'b1, last);
    bb(1'b0, last);
  endtask

  // Bench read: restart after the address, acks one byte, NACKs next
  task automatic rd_frame(output logic [7:0] d0, output logic [7:0] d1,
      output logic [2:0] a);
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    tx({pot_pkg::DEV_PREFIX, straps, pot_pkg::DIR_WRITE}, 8, a[2]);
    tx(pot_pkg::WIPER_ADDR, 8, a[1]);
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    tx({pot_pkg::DEV_PREFIX, straps, pot_pkg::DIR_READ}, 8, a[0]);
    rx(1'b0, d0);
    rx(1'b1, d1);
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic test_bitbang();
    logic [2:0] a;
    logic [7:0] d0, d1;
    frame(8'h11, 8, a);
    chk({5'h00, a}, 8'h07);
    rst2 = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(wiper2, pot_pkg::WIPER_RESET);
    frame(8'h96, 8, a);
    chk({5'h00, a}, 8'h00);
    chk(wiper2, 8'h96);
    rd_frame(d0, d1, a);
    chk({5'h00, a}, 8'h00);
    chk(d0, 8'h96);
    chk(d1, 8'h96);
    frame(8'h3C, 4, a);
    chk(wiper2, 8'h96);
    // Stray clocks after a STOP must not finish the cut byte
    repeat (3) begin
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
    end
    repeat (8) @(posedge ref_clk);
    #1;
    chk(wiper2, 8'h96);
    frame(8'h3C, 8, a);
    chk(wiper2, 8'h3C);
    $display("test bitbang done");
  endtask

  // Main sequence
  initial begin
    link2.m_scl_o = 1'b0;
    link2.m_sda_o = 1'b0;
    link2.m_scl_oe = 1'b0;
    link2.m_sda_oe = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    test_reset();
    test_wiper();
    test_acr();
    test_unmapped();
    test_bitbang();
    report_and_stop();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
